// file: logic/seq_pkg.sv
// Shared constants and types for the timed handshake sequencer link.
package seq_pkg;

    // ************************************************************
    // Link word layout
    // ************************************************************
    localparam int NUM_CARDS = 4;               // Card slots served.
    localparam int WORD_W    = 8;               // Word payload width.
    typedef logic [1:0] word_kind_t;            // Kind of a link word.
    localparam word_kind_t KIND_CONTROL = 2'h0; // Control word, mode bits.
    localparam word_kind_t KIND_DATA    = 2'h1; // Data word to a card.
    localparam word_kind_t KIND_ABORT   = 2'h2; // Abort character.

    // Control word mode bit positions.
    localparam int MB_SYS_EN   = 0;             // output_system_enable.
    localparam int MB_GATE_EN  = 1;             // transfer_gate_enable.
    localparam int MB_IN_SEL   = 2;             // input_select.
    localparam int MB_TIMED    = 3;             // timed_handshake_mode.
    localparam int MB_IRQ_ARM  = 4;             // interrupt_arm_enable.
    localparam int MODE_W      = 5;             // Number of mode bits.
    localparam logic [MODE_W-1:0] MODE_RESET = 5'h00; // Modes after reset.

    // Data word field positions.
    localparam int DW_SLOT_LO  = 0;             // Card slot, low bit.
    localparam int DW_SLOT_HI  = 1;             // Card slot, high bit.
    localparam int DW_GATE     = 2;             // Gate character present.

    // Serial poll answer.
    localparam logic [7:0] POLL_DONE = 8'h40;   // Device requested service.
    localparam logic [7:0] POLL_IDLE = 8'h00;   // Nothing to report.

    // ************************************************************
    // Controller register map
    // ************************************************************
    localparam logic [7:0] REG_CMD      = 8'h00; // Word to send.
    localparam logic [7:0] REG_STATUS   = 8'h04; // Controller state.
    localparam logic [7:0] REG_IRQ_STAT = 8'h08; // Sticky events, W1C.
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C; // Event mask.
    localparam logic [7:0] REG_POLL     = 8'h10; // Write starts a poll.
    localparam int CMD_KIND_LO = 8;              // Kind field in REG_CMD.
    localparam int EV_SRQ      = 0;              // Service request rose.
    localparam int EV_DONE     = 1;              // Poll returned done.
    localparam int EV_SENT     = 2;              // Word was accepted.
    localparam int EV_W        = 3;              // Number of events.
    localparam logic [EV_W-1:0] EV_RESET = 3'h0; // Events after reset.

endpackage

// file: logic/seq_link_if.sv
// Interface joining the bus controller end and the sequencer device end.
`timescale 1ns/1ps
`default_nettype none
interface seq_link_if;
    import seq_pkg::*;
    logic                word_valid;   // Controller offers a word.
    word_kind_t          word_kind;    // Kind of the offered word.
    logic [WORD_W-1:0]   word_data;    // Payload of the offered word.
    logic                word_ready;   // Device takes the word.
    logic                poll_req;     // One-cycle serial poll request.
    logic                status_valid; // Poll answer strobe.
    logic [7:0]          status_byte;  // Poll answer byte.
    logic                srq;          // Service request level.

    // Controller end drives words and polls.
    modport ctrl (
        output word_valid, word_kind, word_data, poll_req,
        input  word_ready, status_valid, status_byte, srq
    );

    // Device end accepts words and answers polls.
    modport dev (
        input  word_valid, word_kind, word_data, poll_req,
        output word_ready, status_valid, status_byte, srq
    );
endinterface
`default_nettype wire

// file: logic/seq_device.sv
// Sequencer device end: mode bits, card gating, completion flags, service.
// Summary of operation
// - Gate character starts the card's timing sequence.
// - Late timed mode waits for all cards.
// - Serial poll answers 64 when requesting service.
// - Card timeout raises service request; poll clears.
// - Turning timed mode on with no card gated raises service request.
// - Stall all words but the abort while waiting for card flag in timed mode.
// - Stall final control word until transfer finishes.
// - Flagless card gating leaves gate never ending.
// - Abort clears gate left without gate enable.
// - Stuck external flag survives abort; reset only.
// - Controller sets input select before reads.
// - Input select, timed, interrupt arm bits apply.
// - Completion flag in timed mode sets request.
// - Gate enable needed for dependent cards' flags.
`timescale 1ns/1ps
`default_nettype none
module seq_device
    import seq_pkg::*;
(
    // Clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Link to the bus controller.
    seq_link_if.dev                   link,
    // Card side.
    input  wire logic [NUM_CARDS-1:0] card_completion_flag,
    input  wire logic [NUM_CARDS-1:0] card_needs_gate_enable,
    output logic      [NUM_CARDS-1:0] card_gate,
    output logic      [MODE_W-1:0]    card_mode
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int SYNC_W = 2 * NUM_CARDS;      // Flags and straps.
    logic [SYNC_W-1:0] pin_s1_q;                // First stage, raw.
    logic [SYNC_W-1:0] pin_s2_q;                // Second stage.
    logic [SYNC_W-1:0] pin_s3_q;                // Third stage.
    logic [SYNC_W-1:0] pin_filt_q;              // Accepted pin levels.

    // Three stage flops and a held level per pin; a change counts once stages two and three agree.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_s1_q   <= '0;
            pin_s2_q   <= '0;
            pin_s3_q   <= '0;
            pin_filt_q <= '0;
        end else begin
            pin_s1_q   <= {card_needs_gate_enable, card_completion_flag};
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            pin_filt_q <= (pin_s2_q & pin_s3_q)
                        | (pin_filt_q & (pin_s2_q | pin_s3_q));
        end
    end

    // ************************************************************
    // Mode bits and flag line
    // ************************************************************
    logic [MODE_W-1:0]    mode_q;               // Modes in force.
    logic [NUM_CARDS-1:0] flag_raw;             // Synced card flags.
    logic [NUM_CARDS-1:0] needs_en;             // Synced strap levels.
    logic [NUM_CARDS-1:0] flag_eff;             // Flags allowed on line.
    logic [NUM_CARDS-1:0] flag_prev_q;          // Flags one cycle back.
    logic                 timed;                // Timed handshake on.

    assign flag_raw = pin_filt_q[NUM_CARDS-1:0];
    assign needs_en = pin_filt_q[SYNC_W-1:NUM_CARDS];
    assign timed    = mode_q[MB_TIMED];
    // A dependent card reaches the flag line only with gate enable on.
    assign flag_eff = flag_raw
                    & (~needs_en | {NUM_CARDS{mode_q[MB_GATE_EN]}});
    // Mode bits reach every card, input cards use three of them.
    assign card_mode = mode_q;

    // ************************************************************
    // Word acceptance
    // ************************************************************
    logic                 pending;              // Any card still gated.
    logic                 take;                 // Word accepted this cycle.
    logic                 is_ctrl;              // Accepted control word.
    logic                 is_data;              // Accepted data word.
    logic                 is_abort;             // Accepted abort word.
    logic [1:0]           slot;                 // Addressed card slot.

    assign pending = |card_gate;
    // While a timed card waits for its flag, only the abort gets through.
    assign link.word_ready = (link.word_kind == KIND_ABORT)
                           | ~(timed & pending);
    assign take     = link.word_valid & link.word_ready;
    assign is_ctrl  = take & (link.word_kind == KIND_CONTROL);
    assign is_data  = take & (link.word_kind == KIND_DATA);
    assign is_abort = take & (link.word_kind == KIND_ABORT);
    assign slot     = link.word_data[DW_SLOT_HI:DW_SLOT_LO];

    // Only a control word changes the modes; they persist otherwise.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_RESET;
        end else if (is_ctrl) begin
            mode_q <= link.word_data[MODE_W-1:0];
        end
    end

    // ************************************************************
    // Card gates
    // ************************************************************
    // Each card gate opens on its gate character and closes on the
    // trailing edge of its permitted flag. A card with no flag, or one
    // blocked by gate enable, never closes it; the abort clears such a
    // gate, but not one whose flag stands high and never falls.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            card_gate   <= '0;
            flag_prev_q <= '0;
        end else begin
            flag_prev_q <= flag_eff;
            for (int i = 0; i < NUM_CARDS; i++) begin
                if (is_data && link.word_data[DW_GATE] && slot == i) begin
                    card_gate[i] <= 1'b1;
                end else if (flag_prev_q[i] && !flag_eff[i]) begin
                    card_gate[i] <= 1'b0;
                end else if (is_abort && !flag_eff[i]) begin
                    card_gate[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Service request and serial poll
    // ************************************************************
    logic pending_prev_q;                       // Pending one cycle back.
    logic srq_set;                              // Request raising event.
    logic srq_q;                                // Service request level.
    logic [7:0] status_q;                       // Poll answer byte.
    logic       status_valid_q;                 // Poll answer strobe.

    // The request rises when the last gated card finishes in timed mode,
    // which defers it until all cards are done if timed mode came late,
    // or when timed mode is switched on with no card outstanding.
    assign srq_set = (timed & pending_prev_q & ~pending)
                   | (is_ctrl & link.word_data[MB_TIMED]
                      & ~timed & ~pending);

    // Pending history for trailing edge detection.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pending_prev_q <= 1'b0;
        end else begin
            pending_prev_q <= pending;
        end
    end

    // A poll clears the request, but a new event in that cycle wins.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            srq_q <= 1'b0;
        end else if (srq_set) begin
            srq_q <= 1'b1;
        end else if (link.poll_req) begin
            srq_q <= 1'b0;
        end
    end

    // The poll answer stands one cycle after the request.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_q       <= POLL_IDLE;
            status_valid_q <= 1'b0;
        end else begin
            status_valid_q <= link.poll_req;
            if (link.poll_req) begin
                status_q <= srq_q ? POLL_DONE : POLL_IDLE;
            end
        end
    end

    assign link.srq          = srq_q;
    assign link.status_byte  = status_q;
    assign link.status_valid = status_valid_q;

endmodule
`default_nettype wire

// file: logic/seq_controller.sv
// Bus controller end: register port to software, words and polls on link.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module seq_controller
    import seq_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Software register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    // Link to the device.
    seq_link_if.ctrl         link
);

    // ************************************************************
    // Word sender
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,                      // Nothing outstanding.
        ST_SEND = 2'b01                       // Word offered, awaiting take.
    } send_state_e;

    send_state_e       state_q;               // Sender state.
    word_kind_t        kind_q;                // Word kind held.
    logic [WORD_W-1:0] data_q;                // Word payload held.
    logic              need_poll_q;           // Timed mode just enabled.
    logic              accepted;              // Word taken this cycle.
    logic              poll_go;               // Software asked a poll.
    logic              hold_data;             // Data word must wait.

    assign poll_go   = reg_wr & (reg_addr == REG_POLL);
    assign accepted  = (state_q == ST_SEND) & link.word_ready & ~hold_data;
    // After enabling timed mode a poll must come before the first data.
    assign hold_data = need_poll_q & (kind_q == KIND_DATA);
    assign link.word_valid = (state_q == ST_SEND) & ~hold_data;
    assign link.word_kind  = kind_q;
    assign link.word_data  = data_q;
    assign link.poll_req   = poll_go;

    // Load a word from software and offer it until the device takes it.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            kind_q  <= KIND_CONTROL;
            data_q  <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (reg_wr && reg_addr == REG_CMD) begin
                        kind_q  <= reg_wdata[CMD_KIND_LO+1:CMD_KIND_LO];
                        data_q  <= reg_wdata[WORD_W-1:0];
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (accepted) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Track whether a poll is owed; a taken enable wins over a poll.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            need_poll_q <= 1'b0;
        end else if (accepted && kind_q == KIND_CONTROL
                     && data_q[MB_TIMED]) begin
            need_poll_q <= 1'b1;
        end else if (poll_go) begin
            need_poll_q <= 1'b0;
        end
    end

    // ************************************************************
    // Poll result, events and interrupt
    // ************************************************************
    logic [7:0]      last_status_q;           // Last poll byte.
    logic            srq_prev_q;              // Request one cycle back.
    logic [EV_W-1:0] ev_now;                  // Events this cycle.
    logic [EV_W-1:0] ev_stat_q;               // Sticky event bits.
    logic [EV_W-1:0] ev_mask_q;               // Event mask.

    assign ev_now[EV_SRQ]  = link.srq & ~srq_prev_q;
    assign ev_now[EV_DONE] = link.status_valid
                           & (link.status_byte == POLL_DONE);
    assign ev_now[EV_SENT] = accepted;
    assign irq = |(ev_stat_q & ev_mask_q);

    // Store each poll answer and the request history.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            last_status_q <= POLL_IDLE;
            srq_prev_q    <= 1'b0;
        end else begin
            srq_prev_q <= link.srq;
            if (link.status_valid) begin
                last_status_q <= link.status_byte;
            end
        end
    end

    // Sticky events: set beats a write-one clear in the same cycle.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ev_stat_q <= EV_RESET;
        end else if (reg_wr && reg_addr == REG_IRQ_STAT) begin
            ev_stat_q <= (ev_stat_q & ~reg_wdata[EV_W-1:0]) | ev_now;
        end else begin
            ev_stat_q <= ev_stat_q | ev_now;
        end
    end

    // Mask register.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ev_mask_q <= EV_RESET;
        end else if (reg_wr && reg_addr == REG_IRQ_MASK) begin
            ev_mask_q <= reg_wdata[EV_W-1:0];
        end
    end

    // Read data stands the cycle after the read strobe; others read zero.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: begin
                    reg_rdata <= {21'h0, state_q == ST_SEND,
                                  need_poll_q, link.srq, last_status_q};
                end
                REG_IRQ_STAT: reg_rdata <= {29'h0, ev_stat_q};
                REG_IRQ_MASK: reg_rdata <= {29'h0, ev_mask_q};
                default:      reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule
`default_nettype wire

// file: testbench/seq_link_asserts.sv
// Link assertions for the controller to device interface.
`timescale 1ns/1ps
`default_nettype none
module seq_link_asserts
    import seq_pkg::*;
(
    // Clock and reset.
    input wire logic              sys_clk,
    input wire logic              rst,
    // Link signals.
    input wire logic              word_valid,
    input wire word_kind_t        word_kind,
    input wire logic [WORD_W-1:0] word_data,
    input wire logic              word_ready,
    input wire logic              poll_req,
    input wire logic              status_valid,
    input wire logic [7:0]        status_byte,
    input wire logic              srq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic timed_q; // Timed mode as set by the last taken control word.

    // ************************************************************
    // Helper logic
    // ************************************************************
    // Track the timed mode bit so stalls can be tied to it.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timed_q <= 1'b0;
        end else if (word_valid && word_ready
                     && word_kind == KIND_CONTROL) begin
            timed_q <= word_data[MB_TIMED];
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    chk_poll_answer: assert property (poll_req |=> status_valid)
        else $error("poll not answered");
    chk_status_cause: assert property (
        status_valid |-> $past(poll_req)) else $error("answer without poll");
    chk_poll_done: assert property (poll_req && srq |=>
        status_byte == POLL_DONE) else $error("poll byte not done");
    chk_poll_idle: assert property (poll_req && !srq |=>
        status_byte == POLL_IDLE) else $error("poll byte not idle");
    chk_status_stable: assert property (
        !poll_req |=> $stable(status_byte))
        else $error("status byte moved without poll");
    chk_srq_hold: assert property (srq && !poll_req |=> srq)
        else $error("service request dropped without poll");
    chk_abort_ready: assert property (word_valid &&
        word_kind == KIND_ABORT |-> word_ready) else $error("abort stalled");
    chk_stall_timed: assert property (!word_ready |-> timed_q)
        else $error("stall outside timed mode");
    chk_word_hold: assert property (word_valid && !word_ready |=>
        word_valid && $stable(word_kind) && $stable(word_data))
        else $error("stalled word changed");
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the sequencer controller and device pair.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import seq_pkg::*;
    logic                 sys_clk, rst, reg_wr, reg_rd, irq; // Drives.
    logic [7:0]           reg_addr;     // Register address.
    logic [31:0]          reg_wdata;    // Register write data.
    logic [31:0]          reg_rdata;    // Register read data.
    logic [31:0]          s;            // Last read value.
    logic [NUM_CARDS-1:0] card_completion_flag, card_needs_gate_enable;
    logic [NUM_CARDS-1:0] card_gate;    // Gate outputs.
    logic [MODE_W-1:0]    card_mode;    // Mode outputs.
    int                   err_count, tests_run; // Counters.

    seq_link_if u_seq_link_if ();
    seq_controller u_seq_controller (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .link(u_seq_link_if.ctrl));
    seq_device u_seq_device (.sys_clk(sys_clk), .rst(rst),
        .link(u_seq_link_if.dev), .card_completion_flag(card_completion_flag),
        .card_needs_gate_enable(card_needs_gate_enable),
        .card_gate(card_gate), .card_mode(card_mode));
    seq_link_asserts u_seq_link_asserts (.sys_clk(sys_clk), .rst(rst),
        .word_valid(u_seq_link_if.word_valid),
        .word_kind(u_seq_link_if.word_kind),
        .word_data(u_seq_link_if.word_data),
        .word_ready(u_seq_link_if.word_ready),
        .poll_req(u_seq_link_if.poll_req),
        .status_valid(u_seq_link_if.status_valid),
        .status_byte(u_seq_link_if.status_byte), .srq(u_seq_link_if.srq));

    always #10 sys_clk = ~sys_clk; // Clock of 50 MHz.

    // ************************************************************
    // Tasks
    // ************************************************************
    // Prints counts and the verdict, then ends the run.
    task results;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Compares one value and counts the result.
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task step(input int n); // Lets n clock cycles pass.
        repeat (n) @(posedge sys_clk);
    endtask
    // One-cycle register write.
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle register read; data taken in the following cycle.
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        s = reg_rdata;
    endtask
    task send(input word_kind_t k, input logic [7:0] p); // Queues a word.
        wr(REG_CMD, {22'h0, k, p});
    endtask
    task poll; // Starts a serial poll and lets it finish.
        wr(REG_POLL, 32'h0);
        step(3);
    endtask
    // Reads status and checks the masked bits.
    task stat(input string n, input logic [31:0] m, input logic [31:0] e);
        rd(REG_STATUS);
        cmp(n, e, s & m);
    endtask
    // Waits, bounded, for one gate output to reach a level.
    task wait_gate(input int i, input logic v);
        int n;
        n = 0;
        while (card_gate[i] !== v && n < 80) begin
            @(negedge sys_clk);
            n++;
        end
        if (card_gate[i] !== v) begin
            $display("MISMATCH gate wait expected %h seen %h", v, card_gate[i]);
            err_count++;
            results();
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        card_completion_flag = 4'h0;
        card_needs_gate_enable = 4'h0;
        err_count = 0;
        tests_run = 0;
        step(4);
        rst <= 1'b0;
        stat("status", 32'hFFFFFFFF, 32'h0);
        cmp("mode", 32'h0, 32'(card_mode));
        rd(8'hFC);
        cmp("unmapped", 32'h0, s);
        $display("test reset done");
        // Serial method: timed on, poll, gate, stalled final word.
        wr(REG_IRQ_MASK, 32'h1);
        send(KIND_CONTROL, 8'h0B);
        step(4);
        cmp("mode", 32'h0B, 32'(card_mode));
        stat("srq", 32'h300, 32'h300);
        cmp("irq", 32'h1, 32'(irq));
        wr(REG_IRQ_STAT, 32'h1);
        @(negedge sys_clk);
        cmp("irq", 32'h0, 32'(irq));
        poll();
        stat("poll", 32'h1FF, 32'h040);
        rd(REG_IRQ_STAT);
        cmp("events", 32'h6, s);
        send(KIND_DATA, 8'h04);
        wait_gate(0, 1'b1);
        send(KIND_CONTROL, 8'h03);
        step(10);
        stat("stall", 32'h500, 32'h400);
        cmp("mode", 32'h0B, 32'(card_mode));
        card_completion_flag <= 4'h1;
        step(8);
        card_completion_flag <= 4'h0;
        wait_gate(0, 1'b0);
        step(4);
        cmp("mode", 32'h03, 32'(card_mode));
        stat("srq", 32'h500, 32'h100);
        cmp("irq", 32'h1, 32'(irq));
        wr(REG_IRQ_STAT, 32'h7);
        poll();
        $display("test serial done");
        // Gate left open by a card needing the gate enable, then abort.
        send(KIND_CONTROL, 8'h09);
        step(3);
        poll();
        card_needs_gate_enable <= 4'h2;
        card_completion_flag <= 4'h2;
        send(KIND_DATA, 8'h05);
        wait_gate(1, 1'b1);
        step(12);
        cmp("gate", 32'h2, 32'(card_gate));
        send(KIND_ABORT, 8'h00);
        step(4);
        cmp("gate", 32'h0, 32'(card_gate));
        card_completion_flag <= 4'h0;
        $display("test abort done");
        // Flag held high survives abort; reset clears it.
        send(KIND_CONTROL, 8'h0B);
        step(3);
        poll();
        card_needs_gate_enable <= 4'h0;
        card_completion_flag <= 4'h4;
        send(KIND_DATA, 8'h06);
        wait_gate(2, 1'b1);
        send(KIND_ABORT, 8'h00);
        step(6);
        cmp("gate", 32'h4, 32'(card_gate));
        rst <= 1'b1;
        card_completion_flag <= 4'h0;
        step(2);
        rst <= 1'b0;
        step(2);
        cmp("gate", 32'h0, 32'(card_gate));
        cmp("mode", 32'h0, 32'(card_mode));
        $display("test stuck flag done");
        // Parallel method: timed mode turned on after two gates open.
        send(KIND_CONTROL, 8'h03);
        send(KIND_DATA, 8'h04);
        send(KIND_DATA, 8'h07);
        wait_gate(3, 1'b1);
        cmp("gate", 32'h9, 32'(card_gate));
        send(KIND_CONTROL, 8'h0B);
        step(4);
        stat("srq", 32'h100, 32'h0);
        card_completion_flag <= 4'h9;
        step(8);
        card_completion_flag <= 4'h8;
        wait_gate(0, 1'b0);
        step(4);
        stat("srq", 32'h100, 32'h0);
        card_completion_flag <= 4'h0;
        wait_gate(3, 1'b0);
        step(4);
        stat("srq", 32'h100, 32'h100);
        poll();
        stat("poll", 32'h1FF, 32'h040);
        $display("test parallel done");
        // Input card modes: input select and interrupt arm, timed off.
        send(KIND_CONTROL, 8'h15);
        step(3);
        cmp("mode", 32'h15, 32'(card_mode));
        $display("test input modes done");
        results();
    end
endmodule
`default_nettype wire
